// [core/osc_word_pkg.sv]
package osc_word_pkg;
    // ========================================
    // Word select codes and field layout
    localparam logic [1:0] SEL_CODE_THIS = 2'h1;
    localparam int SEL_LSB = 0;
    localparam int SIG_LSB = 2;
    localparam int MODE_LSB = 7;
    localparam int REF_STATUS_BIT = 27;
    localparam int SHARED_PIN_BIT = 28;
    localparam int LOCK_TYPE_BIT = 29;
    localparam int DIV4_SHIFT_BIT = 30;
    localparam int DIV8_SHIFT_BIT = 31;
    localparam int NUM_PAIRS = 5;
    localparam int WORD_BITS = 32;
    // ========================================
    // Default values loaded at reset or power-down
    localparam logic [1:0] SEL_DEFAULT = 2'h1;
    localparam logic [4:0] SIG_DEFAULT = 5'h1f;
    localparam logic [19:0] MODE_DEFAULT = 20'h00000;
    localparam logic [31:0] WORD_DEFAULT = 32'h0000007d;

    // Decoded configuration carried to the output logic
    typedef struct packed {
        logic [4:0] signalling_type;  // 1 = differential, 0 = single-ended
        logic [19:0] output_modes;    // Two bits per output, 0A first
        logic ref_status_pin_select;
        logic shared_pin_function_select;
        logic lock_detector_type_select;
        logic quarter_shift_div4_enable;
        logic quarter_shift_div8_enable;
    } out_cfg_t;
endpackage : osc_word_pkg

// [core/output_status_config_word.sv]
// Operation
// [RULE1] Accept word only when select code matches
// [RULE2] Bits 2-6 pick signalling per pair
// [RULE3] Two-bit mode per output, bits 7-26
// [RULE4] Bit 27 picks ref status pin source
// [RULE5] Bit 28 picks shared pin function
// [RULE6] Bit 29 picks digital or analog lock
// [RULE7] Bit 30 enables divide-by-4 quarter shift
// [RULE8] Bit 31 enables divide-by-8 quarter shift
// [RULE9] Host selects feedback divide-by-16 for shifts
// [RULE10] No divide-by-16 output while shift enabled
// [RULE11] Shifted outputs switch together as pairs
// [RULE12] Both shift bits set means no shift
// [RULE13] Defaults: select low, signalling ones, rest zero
// [RULE14] Write-only link, no response
// [RULE15] Defaults restored at power-up and power-down
// [RULE16] Host writes all words after power-up
`timescale 1ns/1ns
module output_status_config_word
    import osc_word_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // Serial control link, write only
    input wire logic i_link_data,
    input wire logic i_link_bit_valid,
    input wire logic i_link_latch,
    // Power-down control, active low
    input wire logic i_power_down_n,
    // Status sources
    input wire logic i_ref_clock_status,
    input wire logic i_primary_reference_clock_selected,
    input wire logic i_digital_lock,
    input wire logic i_analog_lock,
    input wire logic i_oscillator_status,
    // Configuration outputs
    output logic [4:0] o_pair_signalling_type,
    output logic [19:0] o_output_modes,
    output logic o_quarter_shift_div4_active,
    output logic o_quarter_shift_div8_active,
    output logic o_div16_mode_allowed,
    output logic o_pair_switching,
    output logic o_pump_current_reference_pin_enable,
    // Status pins
    output logic o_ref_status_pin,
    output logic o_oscillator_status_out,
    output logic o_lock_pin
);
    logic [WORD_BITS-1:0] rx_word;
    logic rx_valid;
    logic [WORD_BITS-1:0] cfg_word;
    out_cfg_t cfg;
    logic shift4;
    logic shift8;

    // ========================================
    // Serial receiver; the link never answers, so no handshake exists
    word_shift_in u_rx ( // RULE14
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_link_data(i_link_data),
        .i_link_bit_valid(i_link_bit_valid),
        .i_link_latch(i_link_latch),
        .o_word(rx_word),
        .o_word_valid(rx_valid)
    );

    // ========================================
    // Configuration word store
    // Power-down takes priority over a write so defaults always win
    always_ff @(posedge i_clock) begin
        if (i_sys_rst || !i_power_down_n) begin
            cfg_word <= WORD_DEFAULT; // RULE13 RULE15
        end else if (rx_valid && rx_word[SEL_LSB +: 2] == SEL_CODE_THIS) begin
            cfg_word <= rx_word; // RULE1
        end
    end

    // Field decode
    always_comb begin
        cfg.signalling_type = cfg_word[SIG_LSB +: NUM_PAIRS]; // RULE2
        cfg.output_modes = cfg_word[MODE_LSB +: 2*2*NUM_PAIRS]; // RULE3
        cfg.ref_status_pin_select = cfg_word[REF_STATUS_BIT];
        cfg.shared_pin_function_select = cfg_word[SHARED_PIN_BIT];
        cfg.lock_detector_type_select = cfg_word[LOCK_TYPE_BIT];
        cfg.quarter_shift_div4_enable = cfg_word[DIV4_SHIFT_BIT];
        cfg.quarter_shift_div8_enable = cfg_word[DIV8_SHIFT_BIT];
    end

    // Both enables together cancel each other
    assign shift4 = cfg.quarter_shift_div4_enable && !cfg.quarter_shift_div8_enable; // RULE7 RULE12
    assign shift8 = cfg.quarter_shift_div8_enable && !cfg.quarter_shift_div4_enable; // RULE8 RULE12

    // ========================================
    // Registered configuration outputs
    // Shift takes effect from the enable bits alone; the host's feedback divide-by-16 choice is not checked
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_pair_signalling_type <= SIG_DEFAULT;
            o_output_modes <= MODE_DEFAULT;
            o_quarter_shift_div4_active <= 1'b0;
            o_quarter_shift_div8_active <= 1'b0;
            o_div16_mode_allowed <= 1'b1;
            o_pair_switching <= 1'b0;
            o_pump_current_reference_pin_enable <= 1'b0;
        end else begin
            o_pair_signalling_type <= cfg.signalling_type; // RULE2
            o_output_modes <= cfg.output_modes; // RULE3
            o_quarter_shift_div4_active <= shift4; // RULE7 RULE9
            o_quarter_shift_div8_active <= shift8; // RULE8 RULE9
            o_div16_mode_allowed <= !(cfg.quarter_shift_div4_enable
                                      || cfg.quarter_shift_div8_enable); // RULE10
            o_pair_switching <= shift4 || shift8; // RULE11
            o_pump_current_reference_pin_enable <= cfg.shared_pin_function_select; // RULE5
        end
    end

    // ========================================
    // Status pin multiplexing
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_ref_status_pin <= 1'b0;
            o_oscillator_status_out <= 1'b0;
            o_lock_pin <= 1'b0;
        end else begin
            o_ref_status_pin <= cfg.ref_status_pin_select ?
                i_primary_reference_clock_selected : i_ref_clock_status; // RULE4
            // Shared pin carries oscillator status only in its default function
            o_oscillator_status_out <= cfg.shared_pin_function_select ?
                1'b0 : i_oscillator_status; // RULE5
            o_lock_pin <= cfg.lock_detector_type_select ?
                i_analog_lock : i_digital_lock; // RULE6
        end
    end

    // ========================================
    // Checks
    // Each output property samples the stored word one edge ahead of the outputs, so each
    // consequent sits one cycle later than the word that it depends on.
    // Storing a word needs a matching select code and power-down released
    AST_SELECT_FILTER: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE1
        rx_valid && rx_word[1:0] != 2'h1 && i_power_down_n |=> $stable(cfg_word))
        else $error("word with foreign select code was stored");
    // A matching word lands whole one edge after the receiver presents it
    AST_WORD_LOAD: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE1
        rx_valid && rx_word[1:0] == 2'h1 && i_power_down_n |=> cfg_word == $past(rx_word))
        else $error("matching word not stored");
    // Without a received word the store keeps its value
    AST_WORD_HOLD: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE1
        !rx_valid && i_power_down_n |=> $stable(cfg_word))
        else $error("stored word changed without a write");
    // The stored word always carries this word's own select code
    AST_STORED_SEL: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE1
        cfg_word[SEL_LSB +: 2] == SEL_CODE_THIS)
        else $error("stored word has foreign select code");

    // ========================================
    // Output field checks
    // Signalling selectors follow bits 2 to 6
    AST_SIGNAL_OUT: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE2
        ##1 o_pair_signalling_type == $past(cfg_word[6:2]))
        else $error("signalling selectors wrong");
    // Mode bits follow bits 7 to 26
    AST_MODE_OUT: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE3
        ##1 o_output_modes == $past(cfg_word[26:7]))
        else $error("output modes wrong");

    // ========================================
    // Status pin checks
    // Reference status shown by default
    AST_REF_PIN: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE4
        !cfg_word[27] |=> o_ref_status_pin == $past(i_ref_clock_status))
        else $error("ref status pin not showing reference status");
    // Selected clock shown when bit 27 is set
    AST_REF_PIN_SEL: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE4
        cfg_word[REF_STATUS_BIT] |=> o_ref_status_pin == $past(i_primary_reference_clock_selected))
        else $error("ref status pin not showing selected clock");
    // Resistor path enabled and oscillator status held low
    AST_SHARED_PIN: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE5
        cfg_word[28] |=> o_pump_current_reference_pin_enable && !o_oscillator_status_out)
        else $error("shared pin function wrong");
    // Oscillator status passes through in the default function
    AST_OSC_PIN: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE5
        !cfg_word[SHARED_PIN_BIT] |=> !o_pump_current_reference_pin_enable
            && o_oscillator_status_out == $past(i_oscillator_status))
        else $error("oscillator status not passed");
    // Analog lock shown when bit 29 is set
    AST_LOCK_PIN: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE6
        cfg_word[29] |=> o_lock_pin == $past(i_analog_lock))
        else $error("lock pin not analog");
    // Digital lock shown by default
    AST_LOCK_DIG: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE6
        !cfg_word[LOCK_TYPE_BIT] |=> o_lock_pin == $past(i_digital_lock))
        else $error("lock pin not digital");

    // ========================================
    // Phase shift checks
    // Divide-by-4 shift alone switches pairs
    AST_SHIFT4_ON: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE7 RULE11
        cfg_word[DIV4_SHIFT_BIT] && !cfg_word[DIV8_SHIFT_BIT] |=> o_quarter_shift_div4_active
            && !o_quarter_shift_div8_active && o_pair_switching)
        else $error("divide-by-4 shift not applied");
    // Divide-by-8 shift alone switches pairs
    AST_SHIFT8_ON: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE8 RULE11
        cfg_word[DIV8_SHIFT_BIT] && !cfg_word[DIV4_SHIFT_BIT] |=> o_quarter_shift_div8_active
            && !o_quarter_shift_div4_active && o_pair_switching)
        else $error("divide-by-8 shift not applied");
    // No enable: no shift and divide-by-16 offered again
    AST_SHIFT_OFF: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE10
        !cfg_word[DIV4_SHIFT_BIT] && !cfg_word[DIV8_SHIFT_BIT] |=> !o_quarter_shift_div4_active
            && !o_quarter_shift_div8_active && !o_pair_switching && o_div16_mode_allowed)
        else $error("shift active without enable");
    // Both enables cancel out
    AST_BOTH_SHIFT: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE12
        cfg_word[31] && cfg_word[30] |=> !o_quarter_shift_div4_active
            && !o_quarter_shift_div8_active && !o_pair_switching)
        else $error("shift active with both enables");
    // Any enable withdraws divide-by-16
    AST_NO_DIV16: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE10
        (cfg_word[30] || cfg_word[31]) |=> !o_div16_mode_allowed)
        else $error("div16 offered during shift");

    // ========================================
    // Default checks
    // Power-down reloads the whole word, even over a write in flight
    AST_POWER_DOWN: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE15
        !i_power_down_n |=> cfg_word == WORD_DEFAULT)
        else $error("defaults not restored at power-down");
    // Signalling outputs show defaults two edges after power-down
    AST_DEFAULT_SIG: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE13
        !i_power_down_n |=> ##1 o_pair_signalling_type == SIG_DEFAULT)
        else $error("signalling defaults not shown");
    // Mode outputs show defaults two edges after power-down
    AST_DEFAULT_MODE: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE13
        !i_power_down_n |=> ##1 o_output_modes == MODE_DEFAULT)
        else $error("mode defaults not shown");
endmodule : output_status_config_word

// [core/word_shift_in.sv]
`timescale 1ns/1ns
module word_shift_in
    import osc_word_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // Serial link
    input wire logic i_link_data,
    input wire logic i_link_bit_valid,
    input wire logic i_link_latch,
    // Assembled word
    output logic [WORD_BITS-1:0] o_word,
    output logic o_word_valid
);
    logic [WORD_BITS-1:0] shift;

    // ========================================
    // Shift, MSB first; latch presents the whole word as one pulse
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            shift <= '0;
            o_word <= '0;
            o_word_valid <= 1'b0;
        end else begin
            o_word_valid <= i_link_latch;
            if (i_link_latch) begin
                o_word <= shift;
            end
            if (i_link_bit_valid) begin
                shift <= {shift[WORD_BITS-2:0], i_link_data};
            end
        end
    end
endmodule : word_shift_in

// [testbench/serial_host_model.sv]
`timescale 1ns/1ns
module serial_host_model
    import osc_word_pkg::*;
(
    // Clock and request
    input wire logic i_clock,
    input wire logic i_start,
    input wire logic [WORD_BITS-1:0] i_word,
    // Serial link, device only listens
    output logic o_link_data,
    output logic o_link_bit_valid,
    output logic o_link_latch,
    output logic o_busy
);
    logic [5:0] cnt;
    logic [WORD_BITS-1:0] shreg;
    initial begin
        {o_link_data, o_link_bit_valid, o_link_latch, o_busy, cnt, shreg} = '0;
    end
    // Whole word, MSB first, then latch; no answer is awaited
    always @(posedge i_clock) begin
        o_link_bit_valid <= 1'b0;
        o_link_latch <= 1'b0;
        if (!o_busy && i_start) begin
            o_busy <= 1'b1;
            shreg <= i_word;
            cnt <= 6'h00;
        end else if (o_busy && cnt < 6'h20) begin
            o_link_data <= shreg[WORD_BITS-1];
            shreg <= shreg << 1;
            o_link_bit_valid <= 1'b1;
            cnt <= cnt + 6'h01;
        end else if (o_busy) begin
            o_link_latch <= 1'b1;
            o_busy <= 1'b0;
        end else begin
            // Idle line carries no meaning, so keep it moving
            o_link_data <= ~o_link_data;
        end
    end
endmodule : serial_host_model

// [testbench/tb.sv]
`timescale 1ns/1ns
module tb;
    import osc_word_pkg::*;
    logic i_clock = 1'b0, i_sys_rst = 1'b1, start = 1'b0, pd_n = 1'b1;
    logic ref_st = 1'b1, prim = 1'b0, dig = 1'b1, ana = 1'b0, osc = 1'b1;
    logic [31:0] word = 32'h00000000;
    logic ld, lv, ll, busy, d4, d8, d16, pairs, pump, rpin, opin, lpin;
    logic [4:0] sig;
    logic [19:0] modes;
    int error_cnt = 0, tests_run = 0;
    logic [31:0] rows [7] = '{32'h00000001, 32'h40000001, 32'h80000001, 32'hc0000001,
        32'h38000001, 32'h07ffff81, 32'h0000002d};
    always #20 i_clock = ~i_clock;
    serial_host_model u_serial_host_model (.i_clock(i_clock), .i_start(start), .i_word(word),
        .o_link_data(ld), .o_link_bit_valid(lv), .o_link_latch(ll), .o_busy(busy));
    output_status_config_word u_output_status_config_word (.i_clock(i_clock),
        .i_sys_rst(i_sys_rst), .i_link_data(ld), .i_link_bit_valid(lv), .i_link_latch(ll),
        .i_power_down_n(pd_n), .i_ref_clock_status(ref_st),
        .i_primary_reference_clock_selected(prim), .i_digital_lock(dig),
        .i_analog_lock(ana), .i_oscillator_status(osc), .o_pair_signalling_type(sig),
        .o_output_modes(modes), .o_quarter_shift_div4_active(d4),
        .o_quarter_shift_div8_active(d8), .o_div16_mode_allowed(d16),
        .o_pair_switching(pairs), .o_pump_current_reference_pin_enable(pump),
        .o_ref_status_pin(rpin), .o_oscillator_status_out(opin), .o_lock_pin(lpin));
    // ========================================
    // Expected outputs worked out from a stored word
    function automatic logic [32:0] expect_of(input logic [31:0] w);
        return {w[6:2], w[26:7], w[30] & ~w[31], w[31] & ~w[30], ~(w[30] | w[31]),
            w[30] ^ w[31], w[28], w[27] ? prim : ref_st, w[28] ? 1'b0 : osc,
            w[29] ? ana : dig};
    endfunction : expect_of
    task automatic send(input logic [31:0] w);
        @(posedge i_clock);
        start <= 1'b1;
        word <= w;
        @(posedge i_clock);
        start <= 1'b0;
        #1;
        // Sample busy after the edge has settled, not in the edge's own time step
        for (int n = 0; n < 40 && busy !== 1'b0; n++) begin
            @(posedge i_clock);
            #1;
        end
        // Three edges from latch to outputs, one spare
        repeat (4) @(posedge i_clock);
    endtask : send
    task automatic check(input logic [32:0] exp);
        logic [32:0] act;
        #1;
        act = {sig, modes, d4, d8, d16, pairs, pump, rpin, opin, lpin};
        tests_run++;
        if (act !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got %h exp %h", $time, act, exp);
        end
    endtask : check
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done
    // Watchdog sized well above the roughly 720 cycles of traffic
    initial begin
        #(40 * 3000);
        error_cnt++;
        test_done();
    end
    // ========================================
    // Main sequence
    initial begin
        repeat (6) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        // Registered outputs show the defaults one edge after release
        repeat (2) @(posedge i_clock);
        check(expect_of(WORD_DEFAULT));
        // Second pass flips every status source to exercise the pin muxes
        for (int p = 0; p < 2; p++) begin
            {ref_st, prim, dig, ana, osc} <= p ? 5'h0e : 5'h11;
            foreach (rows[i]) begin
                send(rows[i]);
                check(expect_of(rows[i]));
            end
        end
        // Other select codes leave the stored word alone
        send(32'hfffffffe);
        check(expect_of(rows[6]));
        send(32'hffffffff);
        check(expect_of(rows[6]));
        // Power-down reloads defaults and drops a word sent meanwhile
        @(posedge i_clock);
        pd_n <= 1'b0;
        send(32'h40000001);
        pd_n <= 1'b1;
        repeat (2) @(posedge i_clock);
        check(expect_of(WORD_DEFAULT));
        // Reset in mid-run brings the defaults back as well
        send(rows[5]);
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        repeat (2) @(posedge i_clock);
        check(expect_of(WORD_DEFAULT));
        test_done();
    end
endmodule : tb
